// [hw/adcc_top.v]
`timescale 1ns/1ps
`include "adcc_consts.vh"
module adcc_top (
    input wire clk_in,               // Oscillator clock, 200 MHz
    input wire reset_in,             // Sync reset, active high
    input wire ce_in,                // Clock enable
    input wire [7:0] addr_in,        // Data-space address
    input wire wr_in,                // Write strobe
    input wire rd_in,                // Read strobe
    input wire [7:0] wdata_in,       // Write data
    input wire wait_mode_in,         // Core in Wait mode
    input wire stop_mode_in,         // Core in Stop mode
    input wire cmp_in,               // Analog comparator output
    output reg [7:0] rdata_out,      // Read data, registered
    output reg irq_out,              // Interrupt request
    output reg wake_out,             // Wake request out of Wait
    output reg osc_disable_out,      // Main oscillator disable
    output reg analog_on_out,        // Analog power enable
    output reg [7:0] dac_out         // Trial code to converter
);
    reg conv_irq_enable_reg;
    reg eoc_reg;
    reg conv_power_on_reg;
    reg main_osc_disable_reg;
    reg [7:0] result_reg;
    wire wr_ctrl;
    wire start_pulse;
    wire abort;
    wire sar_busy;
    wire sar_done;
    wire [7:0] sar_trial;
    wire [7:0] sar_result;
    wire conv_enabled;
    wire irq_next;
    // Reset image of the control register, so the enable and flag bits are picked by position
    localparam [7:0] ctrl_rst_value = `ADCC_CTRL_RESET;

    // Converter is live only when powered and not in Stop
    assign conv_enabled = conv_power_on_reg & ~stop_mode_in;
    // Wait mode is not consulted, so conversions carry on through it
    assign wr_ctrl = wr_in & (addr_in == `ADCC_ADDR_CONTROL);
    assign start_pulse = wr_ctrl & wdata_in[`ADCC_BIT_START] & conv_enabled;
    assign abort = ~conv_enabled;
    assign irq_next = eoc_reg & conv_irq_enable_reg;

    adcc_sar u_sar (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .ce_in(ce_in),
        .start_in(start_pulse),
        .abort_in(abort),
        .cmp_in(cmp_in),
        .trial_out(sar_trial),
        .busy_out(sar_busy),
        .done_out(sar_done),
        .result_out(sar_result)
    );

    // Control register; start wins over completion in the same cycle
    always @(posedge clk_in) begin
        if (reset_in) begin
            conv_irq_enable_reg <= ctrl_rst_value[`ADCC_BIT_IRQ_EN];
            eoc_reg <= ctrl_rst_value[`ADCC_BIT_EOC];
            conv_power_on_reg <= 1'b0;
            main_osc_disable_reg <= 1'b0;
        end else if (ce_in) begin
            if (wr_ctrl) begin
                conv_irq_enable_reg <= wdata_in[`ADCC_BIT_IRQ_EN];
                conv_power_on_reg <= wdata_in[`ADCC_BIT_POWER];
                main_osc_disable_reg <= wdata_in[`ADCC_BIT_OSC_OFF];
            end
            // Writes of the flag bit are ignored
            if (start_pulse) begin
                eoc_reg <= 1'b0;
            end else if (sar_done) begin
                eoc_reg <= 1'b1;
            end
        end
    end

    // Result loads once per completion; no automatic restart follows
    always @(posedge clk_in) begin
        if (reset_in) begin
            result_reg <= `ADCC_RESULT_RESET;
        end else if (ce_in && sar_done && !start_pulse) begin
            result_reg <= sar_result;
        end
    end

    // Registered read port and outputs
    always @(posedge clk_in) begin
        if (reset_in) begin
            rdata_out <= 8'h00;
            irq_out <= 1'b0;
            wake_out <= 1'b0;
            osc_disable_out <= 1'b0;
            analog_on_out <= 1'b0;
            dac_out <= 8'h00;
        end else if (ce_in) begin
            if (rd_in && addr_in == `ADCC_ADDR_RESULT) begin
                rdata_out <= result_reg;
            end else if (rd_in && addr_in == `ADCC_ADDR_CONTROL) begin
                // Start and reserved positions read zero
                rdata_out <= {conv_irq_enable_reg, eoc_reg, 1'b0, conv_power_on_reg,
                              1'b0, main_osc_disable_reg, 2'b00};
            end else begin
                rdata_out <= 8'h00;
            end
            irq_out <= irq_next;
            // Wake only from Wait; Stop never woken by this source
            wake_out <= irq_next & wait_mode_in & ~stop_mode_in;
            osc_disable_out <= main_osc_disable_reg;
            analog_on_out <= conv_enabled;
            dac_out <= sar_trial;
        end
    end
endmodule // adcc_top

// [hw/adcc_consts.vh]
`ifndef ADCC_CONSTS_VH
`define ADCC_CONSTS_VH
// Data-space addresses
`define ADCC_ADDR_RESULT 8'hD0
`define ADCC_ADDR_CONTROL 8'hD1
// Control field positions
`define ADCC_BIT_IRQ_EN 7
`define ADCC_BIT_EOC 6
`define ADCC_BIT_START 5
`define ADCC_BIT_POWER 4
`define ADCC_BIT_RSV3 3
`define ADCC_BIT_OSC_OFF 2
// Reset values
`define ADCC_CTRL_RESET 8'h40
`define ADCC_RESULT_RESET 8'h00
// Successive approximation: cycles per bit step and result width
`define ADCC_CYCLES_PER_BIT 8'h08
`define ADCC_RES_BITS 4'h8
`endif

// [hw/adcc_sar.v]
`timescale 1ns/1ps
`include "adcc_consts.vh"
// Bitwise successive-approximation sequencer
module adcc_sar (
    input wire clk_in,            // Oscillator clock
    input wire reset_in,          // Sync reset, active high
    input wire ce_in,             // Clock enable
    input wire start_in,          // Begin or restart a conversion
    input wire abort_in,          // Abandon without result
    input wire cmp_in,            // Comparator: input above trial level
    output reg [7:0] trial_out,   // Trial code to the DAC
    output reg busy_out,          // Conversion running
    output reg done_out,          // One-cycle completion pulse
    output reg [7:0] result_out   // Final code
);
    reg [7:0] mask_reg;
    reg [7:0] wait_reg;

    // Sequencer; a restart simply reloads from the top bit
    always @(posedge clk_in) begin
        if (reset_in) begin
            trial_out <= 8'h00;
            busy_out <= 1'b0;
            done_out <= 1'b0;
            result_out <= 8'h00;
            mask_reg <= 8'h00;
            wait_reg <= 8'h00;
        end else if (ce_in) begin
            done_out <= 1'b0;
            if (start_in) begin
                busy_out <= 1'b1;
                mask_reg <= 8'h80;
                trial_out <= 8'h80;
                wait_reg <= `ADCC_CYCLES_PER_BIT - 8'h01;
            end else if (abort_in) begin
                busy_out <= 1'b0;
                mask_reg <= 8'h00;
            end else if (busy_out) begin
                if (wait_reg != 8'h00) begin
                    wait_reg <= wait_reg - 8'h01;
                end else begin
                    // Keep trial bit if input above level, then try next bit
                    wait_reg <= `ADCC_CYCLES_PER_BIT - 8'h01;
                    mask_reg <= {1'b0, mask_reg[7:1]};
                    if (mask_reg == 8'h01) begin
                        busy_out <= 1'b0;
                        done_out <= 1'b1;
                        result_out <= cmp_in ? trial_out : (trial_out & ~mask_reg);
                    end else begin
                        trial_out <= (cmp_in ? trial_out : (trial_out & ~mask_reg))
                            | {1'b0, mask_reg[7:1]};
                    end
                end
            end
        end
    end
endmodule // adcc_sar

// [sim/adcc_monitor.sv]
`timescale 1ns/1ps
module adcc_monitor (
    input wire clk_in, // Clock
    input wire reset_in, // Sync reset
    input wire ce_in, // Clock enable
    input wire [7:0] addr_in, // Address
    input wire wr_in, // Write strobe
    input wire rd_in, // Read strobe
    input wire [7:0] wdata_in, // Write data
    input wire stop_mode_in, // Stop mode
    input wire [7:0] rdata_out, // Read data
    input wire irq_out, // Interrupt
    input wire wake_out, // Wake
    input wire osc_disable_out, // Osc off
    input wire analog_on_out // Analog power
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in || !ce_in);
    // Control writes and start writes that set the power bit outside Stop
    wire ctl_w = ce_in && wr_in && addr_in == 8'hD1;
    wire strt_w = ctl_w && wdata_in[5] && wdata_in[4] && !stop_mode_in;
    start_clears_a: assert property (strt_w |-> ##[1:2] !irq_out)
        else $error("irq survived start");
    irq_gate_a: assert property (ctl_w && !wdata_in[7] |-> ##[1:2] !irq_out)
        else $error("irq without enable");
    start_reads0_a: assert property (rd_in && addr_in == 8'hD1 |=> !rdata_out[5])
        else $error("start bit read back");
    idle_read_a: assert property (!(rd_in && addr_in[7:1] == 7'h68) |=> rdata_out == 8'h00)
        else $error("stray read data");
    osc_follow_a: assert property ($changed(osc_disable_out) |-> $past(ctl_w) || $past(ctl_w, 2))
        else $error("osc disable moved alone");
    power_off_a: assert property (ctl_w && !wdata_in[4] |-> ##[1:2] !analog_on_out)
        else $error("converter still powered");
    stop_power_a: assert property (stop_mode_in && $past(stop_mode_in) |-> !analog_on_out)
        else $error("powered in stop");
    stop_wake_a: assert property (stop_mode_in && $past(stop_mode_in) |-> !wake_out)
        else $error("wake in stop");
    cover property ($rose(irq_out));
    cover property ($rose(wake_out));
    cover property (strt_w ##[2:30] strt_w);
endmodule // adcc_monitor

// [sim/adcc_ain_model.sv]
`timescale 1ns/1ps
module adcc_ain_model (
    input wire [7:0] level_in, // Input level as a code
    input wire [7:0] dac_in, // Trial code
    output wire cmp_out // High at or above trial
);
    // Ideal comparator, so the search saturates at 00h and FFh
    assign cmp_out = level_in >= dac_in;
endmodule // adcc_ain_model

// [sim/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    logic clk_in, reset_in, ce_in, wr_in, rd_in, wait_mode_in, stop_mode_in;
    logic [7:0] addr_in, wdata_in, lvl, d;
    wire [7:0] rdata_out, dac_out;
    wire irq_out, wake_out, osc_disable_out, analog_on_out, cmp_in;
    int fails, checks_done, k;
    adcc_top dut_u (.clk_in(clk_in), .reset_in(reset_in), .ce_in(ce_in), .addr_in(addr_in),
        .wr_in(wr_in), .rd_in(rd_in), .wdata_in(wdata_in), .wait_mode_in(wait_mode_in),
        .stop_mode_in(stop_mode_in), .cmp_in(cmp_in), .rdata_out(rdata_out),
        .irq_out(irq_out), .wake_out(wake_out), .osc_disable_out(osc_disable_out),
        .analog_on_out(analog_on_out), .dac_out(dac_out));
    adcc_ain_model ain_u (.level_in(lvl), .dac_in(dac_out), .cmp_out(cmp_in));
    // 200 MHz clock
    always #2.5 clk_in = ~clk_in;
    task chk(input string n, input [7:0] s, input [7:0] e);
        checks_done++;
        if (s !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Bus cycles start 1 ns after the edge
    task wr(input [7:0] a, input [7:0] v);
        @(posedge clk_in); #1 wr_in = 1; addr_in = a; wdata_in = v;
        @(posedge clk_in); #1 wr_in = 0;
    endtask
    task rd(input [7:0] a);
        @(posedge clk_in); #1 rd_in = 1; addr_in = a;
        @(posedge clk_in); #1 rd_in = 0; d = rdata_out;
    endtask
    task cy(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    // Bounded wait for the end-of-conversion request
    task wirq;
        int i;
        for (i = 0; i < 300 && irq_out !== 1'b1; i++) cy(1);
        if (i == 300) begin
            fails++;
            summarize;
        end
    endtask
    // Full conversion, expected code is the level itself
    task conv(input [7:0] v);
        lvl = v;
        wr(8'hD1, 8'hB0);
        cy(3);
        wirq;
        rd(8'hD0);
        chk("result", d, v);
    endtask
    initial begin
        clk_in = 0; reset_in = 1; ce_in = 1; wr_in = 0; rd_in = 0; addr_in = 0; wdata_in = 0;
        wait_mode_in = 0; stop_mode_in = 0; fails = 0; checks_done = 0; lvl = 8'($urandom(61));
        cy(16);
        reset_in = 0;
        rd(8'hD1); chk("ctrl_rst", d, 8'h40);
        rd(8'hD0); chk("res_rst", d, 8'h00);
        chk("power_rst", {7'h0, analog_on_out}, 8'h00);
        $display("test reset done");
        wr(8'hD1, 8'h10);
        wr(8'hD0, 8'h5A);
        for (k = 0; k < 3; k++) conv(k == 0 ? 8'h00 : k == 1 ? 8'hFF : 8'($urandom));
        rd(8'hD1); chk("ctrl_done", d, 8'hD0);
        rd(8'h80); chk("unmapped", d, 8'h00);
        $display("test convert done");
        wr(8'hD1, 8'h14); rd(8'hD1); chk("ctrl_flag", d, 8'h54);
        chk("osc", {7'h0, osc_disable_out}, 8'h01);
        chk("irq_off", {7'h0, irq_out}, 8'h00);
        wr(8'hD1, 8'h10);
        $display("test flags done");
        lvl = 8'h33; wr(8'hD1, 8'hB0); cy(20);
        chk("irq_clr", {7'h0, irq_out}, 8'h00);
        conv(8'hC5);
        cy(80); chk("one_shot", {7'h0, irq_out}, 8'h01);
        $display("test restart done");
        // Clock enable low mid-conversion must freeze the search
        lvl = 8'h21; wr(8'hD1, 8'hB0); cy(10); ce_in = 0; d = dac_out;
        cy(100); chk("ce_dac", dac_out, d);
        chk("ce_irq", {7'h0, irq_out}, 8'h00);
        ce_in = 1; wirq; rd(8'hD0); chk("ce_res", d, 8'h21);
        $display("test enable done");
        wait_mode_in = 1; conv(8'h6B); cy(1);
        chk("wake", {7'h0, wake_out}, 8'h01);
        stop_mode_in = 1; cy(3); wr(8'hD1, 8'hB0); cy(3);
        chk("stop_wake", {1'b0, wake_out, 5'h0, analog_on_out}, 8'h00);
        chk("stop_start", {7'h0, irq_out}, 8'h01);
        $display("test low power done");
        summarize;
    end
endmodule // tb_top
bind adcc_top adcc_monitor mon_u (.clk_in(clk_in), .reset_in(reset_in), .ce_in(ce_in),
    .addr_in(addr_in), .wr_in(wr_in), .rd_in(rd_in), .wdata_in(wdata_in),
    .stop_mode_in(stop_mode_in), .rdata_out(rdata_out), .irq_out(irq_out),
    .wake_out(wake_out), .osc_disable_out(osc_disable_out), .analog_on_out(analog_on_out));
